//--- include/ctm_regs.svh
// What this block does
// - 10-bit up counter clocked from a selected internal or external source.
// - Period comparator is 3 bits, compared with counter bits 9 to 7.
// - Compare A register holds 10 bits, compared with the whole counter.
// - Software cannot load the counter; run bit rising clears it to zero.
// - Counter also clears on overflow or compare match; only the compare matches raise interrupts.
// - Two interrupt requests: one for comparator A, one for comparator P.
// - A compare match can clear the counter and change the output pin.
// - Three-bit clock select picks system, high, sub clock ratios or pin.
// - External pin edge is selectable rising or falling for event counting.
// - Compare output mode drives pin high, low or toggles on match.
// - Output pin carries edge-aligned PWM with adjustable duty or period.
// - Modes are compare output, timer/counter and PWM; no capture or pulse.
// - Counter is a read-only pair; compare A is a read/write pair.
// - Low byte write of compare A only fills the 8-bit holding buffer.
// - High byte write stores high bits and copies buffer into low byte.
// - High byte read returns it and latches the matching low byte.
// - Low byte read returns the holding buffer, not the live low byte.
// - Two control registers hold settings including the period compare bits.
// - Mode 00 compare output, 10 PWM, 11 timer/counter, 01 undefined.
// - Clock select 110 picks pin rising edge, 111 pin falling edge.
// - Period value steps of 128 clocks; 000 means 1024 clocks, full overflow.
// - Outside PWM, clear select high clears on A match; low on P match or overflow.
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CTM_OFS_CTRL0 3'h0
`define CTM_OFS_CTRL1 3'h1
`define CTM_OFS_CNT_LO 3'h2
`define CTM_OFS_CNT_HI 3'h3
`define CTM_OFS_CMPA_LO 3'h4
`define CTM_OFS_CMPA_HI 3'h5
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTM_C0_PAUSE 7
`define CTM_C0_CKSEL_HI 6
`define CTM_C0_CKSEL_LO 4
`define CTM_C0_RUN 3
`define CTM_C0_RP_HI 2
`define CTM_C1_MODE_HI 7
`define CTM_C1_MODE_LO 6
`define CTM_C1_IO_HI 5
`define CTM_C1_IO_LO 4
`define CTM_C1_INIT 3
`define CTM_C1_INV 2
`define CTM_C1_SWAP 1
`define CTM_C1_CLRSEL 0
`define CTM_RST_CTRL 8'h00
// ----------------------------------------
// Timing counts
// ----------------------------------------
`define CTM_DIV_SYS4 8'h04
`define CTM_DIV_H16 8'h10
`define CTM_DIV_H64 8'h40
`endif

//--- include/ctm_pkg.sv
package ctm_pkg;
   // Operating modes in the mode field
   typedef enum logic [1:0] {
      CTM_MODE_CMP = 2'b00,
      CTM_MODE_UNDEF = 2'b01,
      CTM_MODE_PWM = 2'b10,
      CTM_MODE_TMR = 2'b11
   } ctm_mode_t;
   // Register bus request
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ctm_bus_t;
endpackage

//--- rtl/ctm_div.sv
`timescale 1ns/100ps
`default_nettype none
// Free-running prescaler, one-cycle tick every DIV enabled cycles
module ctm_div #(
   parameter logic [7:0] DIV = 8'h04
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic en,
   output logic tick
);
   logic [7:0] cnt_r;
   // ----------------------------------------
   // Counter
   // ----------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 8'h00;
      end else if (en) begin
         cnt_r <= (cnt_r == DIV - 8'h01) ? 8'h00 : cnt_r + 8'h01;
      end
   end
   assign tick = en && (cnt_r == DIV - 8'h01);
endmodule
`default_nettype wire

//--- rtl/ctm_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ctm_regs.svh"
// Compact 10-bit timer: counter, two comparators, output pin, byte-split regs
module ctm_top
   import ctm_pkg::*;
#(
   parameter int CW = 10
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire ctm_bus_t bus,
   output logic [7:0] rdata,
   input wire logic high_clk_tick,
   input wire logic sub_clk_tick,
   input wire logic external_clock_pin,
   output logic timer_output_pin,
   output logic irq_cmp_a,
   output logic irq_cmp_p
);
   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   logic [7:0] ctrl0_r, ctrl1_r, hold_r, rdata_r;
   logic [1:0] cmpa_hi_r;
   logic [7:0] cmpa_lo_r;
   logic [CW-1:0] cnt_r;
   logic run_d_r, out_r, irq_a_r, irq_p_r;
   logic [1:0] pin_sync_r;
   logic pin_prev_r;

   // Field decode
   wire logic pause = ctrl0_r[`CTM_C0_PAUSE];
   wire logic [2:0] cksel = ctrl0_r[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
   wire logic run = ctrl0_r[`CTM_C0_RUN];
   wire logic [2:0] period_compare_bits = ctrl0_r[`CTM_C0_RP_HI:0];
   wire ctm_mode_t mode = ctm_mode_t'(ctrl1_r[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO]);
   wire logic [1:0] io_sel = ctrl1_r[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
   wire logic init_lvl = ctrl1_r[`CTM_C1_INIT];
   wire logic invert = ctrl1_r[`CTM_C1_INV];
   wire logic swap = ctrl1_r[`CTM_C1_SWAP];
   wire logic clr_sel = ctrl1_r[`CTM_C1_CLRSEL];
   wire logic [CW-1:0] cmpa = {cmpa_hi_r, cmpa_lo_r};

   // ----------------------------------------
   // Clock source selection
   // ----------------------------------------
   logic t_sys4, t_h16, t_h64;
   ctm_div #(.DIV(`CTM_DIV_SYS4)) u_sys4 (.clk(clk), .reset_n(reset_n), .en(1'b1), .tick(t_sys4));
   ctm_div #(.DIV(`CTM_DIV_H16)) u_h16 (.clk(clk), .reset_n(reset_n), .en(high_clk_tick), .tick(t_h16));
   ctm_div #(.DIV(`CTM_DIV_H64)) u_h64 (.clk(clk), .reset_n(reset_n), .en(high_clk_tick), .tick(t_h64));

   // Pin edge seen from second sync stage only, so the first stage stays clean
   wire logic pin_rise = pin_sync_r[1] && !pin_prev_r;
   wire logic pin_fall = !pin_sync_r[1] && pin_prev_r;
   logic src_tick;
   always_comb begin
      unique case (cksel)
         3'b000: src_tick = t_sys4;
         3'b001: src_tick = 1'b1;
         3'b010: src_tick = t_h16;
         3'b011: src_tick = t_h64;
         3'b100: src_tick = sub_clk_tick;
         3'b101: src_tick = sub_clk_tick;
         3'b110: src_tick = pin_rise;
         3'b111: src_tick = pin_fall;
      endcase
   end
   wire logic step = run && !pause && src_tick;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_sync_r <= 2'b00;
         pin_prev_r <= 1'b0;
      end else begin
         pin_sync_r <= {pin_sync_r[0], external_clock_pin};
         pin_prev_r <= pin_sync_r[1];
      end
   end

   // ----------------------------------------
   // Comparators and clear
   // ----------------------------------------
   // Matches are evaluated on the count about to be reached, so the output level and
   // interrupt move in the same tick as the counter value; the pin follows one cycle later
   wire logic [CW-1:0] cnt_inc = cnt_r + 10'h001;
   wire logic match_a = step && (cnt_inc == cmpa);
   // Period value 000 means the top bits wrap to zero: full 1024-clock overflow
   wire logic match_p = step && (cnt_inc[CW-1:CW-3] == period_compare_bits)
                        && (cnt_inc[CW-4:0] == 7'h00);
   wire logic overflow = step && (cnt_r == 10'h3FF);
   wire logic pwm_mode = (mode == CTM_MODE_PWM);
   // In PWM the period register clears; clear select is ignored there
   wire logic per_match = pwm_mode ? (swap ? match_a : match_p) : 1'b0;
   wire logic duty_match = pwm_mode ? (swap ? match_p : match_a) : 1'b0;
   wire logic clr_evt = pwm_mode ? per_match :
                        (clr_sel ? match_a : (match_p || overflow));
   wire logic run_rise = run && !run_d_r;

   // Counter: no software load path
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 10'h000;
         run_d_r <= 1'b0;
      end else begin
         run_d_r <= run;
         if (run_rise) begin
            cnt_r <= 10'h000;
         end else if (clr_evt) begin
            cnt_r <= 10'h000;
         end else if (step) begin
            cnt_r <= cnt_inc;
         end
      end
   end

   // Counter checks; run rise and clear outrank a step, so the guards leave them out
   run_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !run |=> $stable(cnt_r))
      else $error("counter moved while off");
   pause_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (pause && !run_rise) |=> $stable(cnt_r))
      else $error("counter moved while paused");
   fast_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      (cksel == 3'b001 && run && !pause && !run_rise && !clr_evt) |=> cnt_r == $past(cnt_r) + 10'h001)
      else $error("full rate source missed a step");
   p_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!pwm_mode && !clr_sel && match_p && !run_rise) |=> cnt_r == 10'h000)
      else $error("P clear missed");
   ovf_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!pwm_mode && !clr_sel && overflow && !run_rise) |=> cnt_r == 10'h000)
      else $error("overflow clear missed");
   pwm_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      (pwm_mode && per_match && !run_rise) |=> cnt_r == 10'h000)
      else $error("PWM period clear missed");
   sys_div_a: assert property (@(posedge clk) disable iff (!reset_n)
      t_sys4 |=> !t_sys4 ##1 !t_sys4 ##1 !t_sys4 ##1 t_sys4)
      else $error("quarter rate tick spacing wrong");
   sub_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      (cksel[2:1] == 2'b10 && step) |-> sub_clk_tick)
      else $error("sub clock step without tick");
   ext_fall_a: assert property (@(posedge clk) disable iff (!reset_n)
      (cksel == 3'b111 && step) |-> !$past(external_clock_pin, 2) && $past(external_clock_pin, 3))
      else $error("count without falling edge");

   // Interrupt requests, one pulse per match
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_a_r <= 1'b0;
         irq_p_r <= 1'b0;
      end else begin
         irq_a_r <= match_a;
         irq_p_r <= match_p;
      end
   end

   // Interrupt checks; a P pulse only ever lands on a 128-step boundary
   irq_p_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
      match_p |=> irq_cmp_p)
      else $error("missing P interrupt");
   irq_a_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
      irq_cmp_a |-> $past(match_a))
      else $error("spurious A interrupt");
   p_multiple_a: assert property (@(posedge clk) disable iff (!reset_n)
      irq_cmp_p |-> $past(cnt_inc[6:0]) == 7'h00)
      else $error("P match off a 128 boundary");

   // ----------------------------------------
   // Output pin
   // ----------------------------------------
   // Output is held as the active-high internal level; polarity applied after
   logic out_nxt;
   always_comb begin
      out_nxt = out_r;
      if (run_rise) begin
         out_nxt = pwm_mode ? 1'b0 : init_lvl;
      end else if (mode == CTM_MODE_CMP && match_a) begin
         unique case (io_sel)
            2'b00: out_nxt = out_r;
            2'b01: out_nxt = 1'b0;
            2'b10: out_nxt = 1'b1;
            2'b11: out_nxt = !out_r;
         endcase
      end else if (pwm_mode) begin
         unique case (io_sel)
            2'b00: out_nxt = 1'b0;
            2'b01: out_nxt = 1'b1;
            2'b10: out_nxt = per_match ? 1'b1 : (duty_match ? 1'b0 : out_r);
            2'b11: out_nxt = out_r;
         endcase
      end
   end
   // PWM active level follows init bit; timer mode leaves the pin at rest
   wire logic pin_lvl = pwm_mode ? (init_lvl ? out_r : !out_r) : out_r;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         out_r <= 1'b0;
         timer_output_pin <= 1'b0;
      end else begin
         out_r <= out_nxt;
         timer_output_pin <= (mode == CTM_MODE_TMR) ? 1'b0 : (pin_lvl ^ invert);
      end
   end

   // Output checks; the pin trails the internal level by one register stage
   init_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      (run_rise && !pwm_mode) |=> out_r == $past(init_lvl))
      else $error("output not set to initial level");
   cmp_high_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == CTM_MODE_CMP && match_a && io_sel == 2'b10 && !run_rise) |=> out_r)
      else $error("output not driven high");
   cmp_low_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == CTM_MODE_CMP && match_a && io_sel == 2'b01 && !run_rise) |=> !out_r)
      else $error("output not driven low");
   cmp_toggle_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == CTM_MODE_CMP && match_a && io_sel == 2'b11 && !run_rise) |=> out_r != $past(out_r))
      else $error("output not toggled");
   cmp_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == CTM_MODE_CMP) |=> timer_output_pin == ($past(out_r) ^ $past(invert)))
      else $error("pin does not follow output level");
   timer_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
      (mode == CTM_MODE_TMR) |=> !timer_output_pin)
      else $error("pin driven in timer mode");
   pwm_start_a: assert property (@(posedge clk) disable iff (!reset_n)
      (run_rise && pwm_mode) |=> !out_r)
      else $error("PWM not started inactive");
   pwm_active_a: assert property (@(posedge clk) disable iff (!reset_n)
      (pwm_mode && io_sel == 2'b10 && per_match && !run_rise) |=> out_r)
      else $error("PWM not active at period start");
   pwm_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      (pwm_mode && io_sel == 2'b10 && duty_match && !per_match && !run_rise) |=> !out_r)
      else $error("PWM not inactive after duty");

   // ----------------------------------------
   // Register bus
   // ----------------------------------------
   wire logic wr_c0 = bus.wr && bus.addr == `CTM_OFS_CTRL0;
   wire logic wr_c1 = bus.wr && bus.addr == `CTM_OFS_CTRL1;
   wire logic wr_alo = bus.wr && bus.addr == `CTM_OFS_CMPA_LO;
   wire logic wr_ahi = bus.wr && bus.addr == `CTM_OFS_CMPA_HI;
   wire logic rd_dhi = bus.rd && bus.addr == `CTM_OFS_CNT_HI;
   wire logic rd_ahi = bus.rd && bus.addr == `CTM_OFS_CMPA_HI;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl0_r <= `CTM_RST_CTRL;
         ctrl1_r <= `CTM_RST_CTRL;
         cmpa_hi_r <= 2'b00;
         cmpa_lo_r <= 8'h00;
      end else begin
         if (wr_c0) ctrl0_r <= bus.wdata;
         if (wr_c1) ctrl1_r <= bus.wdata;
         if (wr_ahi) begin
            cmpa_hi_r <= bus.wdata[1:0];
            cmpa_lo_r <= hold_r;
         end
      end
   end

   // Shared holding buffer; software order keeps its use unambiguous
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_r <= 8'h00;
      end else if (wr_alo) begin
         hold_r <= bus.wdata;
      end else if (rd_dhi) begin
         hold_r <= cnt_r[7:0];
      end else if (rd_ahi) begin
         hold_r <= cmpa_lo_r;
      end
   end

   // Read data, valid the cycle after the strobe; unmapped reads give zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      unique case (bus.addr)
         `CTM_OFS_CTRL0: rd_mux = ctrl0_r;
         `CTM_OFS_CTRL1: rd_mux = ctrl1_r;
         `CTM_OFS_CNT_LO: rd_mux = hold_r;
         `CTM_OFS_CNT_HI: rd_mux = {6'h00, cnt_r[9:8]};
         `CTM_OFS_CMPA_LO: rd_mux = hold_r;
         `CTM_OFS_CMPA_HI: rd_mux = {6'h00, cmpa_hi_r};
         default: rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= bus.rd ? rd_mux : 8'h00;
      end
   end
   assign rdata = rdata_r;
   assign irq_cmp_a = irq_a_r;
   assign irq_cmp_p = irq_p_r;

   // Bus checks; read data stand for one cycle only and are zero otherwise
   rd_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      !bus.rd |=> rdata == 8'h00)
      else $error("read data without read");
   cnt_lo_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == `CTM_OFS_CNT_LO) |=> rdata == $past(hold_r))
      else $error("counter low read not from buffer");
   cmpa_lo_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      (bus.rd && bus.addr == `CTM_OFS_CMPA_LO) |=> rdata == $past(hold_r))
      else $error("compare low read not from buffer");
   cnt_hi_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      rd_dhi |=> rdata == {6'h00, $past(cnt_r[9:8])})
      else $error("counter high read wrong");
   hi_bits_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_ahi |=> cmpa_hi_r == $past(bus.wdata[1:0]))
      else $error("compare high bits not stored");
   cmpa_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
      !wr_ahi |=> $stable(cmpa_hi_r) && $stable(cmpa_lo_r))
      else $error("compare value moved without high write");
   a_hi_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      rd_ahi |=> hold_r == $past(cmpa_lo_r))
      else $error("compare low not latched");
   ctrl0_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_c0 |=> ctrl0_r == $past(bus.wdata))
      else $error("first control write lost");
   ctrl1_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_c1 |=> ctrl1_r == $past(bus.wdata))
      else $error("second control write lost");

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   run_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(run) |=> cnt_r == 10'h000) else $error("counter not cleared on run");
   no_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!run_rise && !clr_evt && !step) |=> $stable(cnt_r)) else $error("counter moved without cause");
   count_step_a: assert property (@(posedge clk) disable iff (!reset_n)
      (step && !clr_evt && !run_rise) |=> cnt_r == $past(cnt_r) + 10'h001) else $error("bad count step");
   irq_a_a: assert property (@(posedge clk) disable iff (!reset_n)
      match_a |=> irq_cmp_a) else $error("missing A interrupt");
   irq_p_a: assert property (@(posedge clk) disable iff (!reset_n)
      irq_cmp_p |-> $past(cnt_inc[9:7]) == $past(period_compare_bits)) else $error("spurious P interrupt");
   buf_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_alo |=> $stable(cmpa_lo_r) && hold_r == $past(bus.wdata)) else $error("low write reached register");
   hi_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_ahi |=> cmpa_lo_r == $past(hold_r)) else $error("buffer not copied");
   hi_read_a: assert property (@(posedge clk) disable iff (!reset_n)
      rd_dhi |=> hold_r == $past(cnt_r[7:0])) else $error("counter low not latched");
   clr_a_sel_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!pwm_mode && clr_sel && match_a && !run_rise) |=> cnt_r == 10'h000) else $error("A clear missed");
   ext_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
      (cksel == 3'b110 && step) |-> $past(external_clock_pin, 2) && !$past(external_clock_pin, 3))
      else $error("count without edge");
endmodule
`default_nettype wire

//--- testbench/tb_ctm_top.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Self-checking bench for the compact timer
// ----------------------------------------
module tb_ctm_top
   import ctm_pkg::*;
;
   logic clk;
   logic reset_n;
   logic hi_tick;
   logic ext_pin;
   ctm_bus_t bus;
   logic [7:0] rdata;
   logic pin;
   logic irq_a;
   logic irq_p;
   logic pin_q = 1'b0;
   logic [1:0] sub_cnt = 2'h0;
   logic [2:0] ev;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Clock select and period bits per entry, with the expected P match spacing
   logic [5:0] cfg [9] = '{6'o11, 6'o01, 6'o21, 6'o31, 6'o41, 6'o51, 6'o12, 6'o17, 6'o10};
   int per [9] = '{128, 512, 2048, 8192, 512, 512, 256, 896, 1024};

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   ctm_top uut (
      .clk(clk),
      .reset_n(reset_n),
      .bus(bus),
      .rdata(rdata),
      .high_clk_tick(hi_tick),
      .sub_clk_tick(sub_cnt == 2'h3),
      .external_clock_pin(ext_pin),
      .timer_output_pin(pin),
      .irq_cmp_a(irq_a),
      .irq_cmp_p(irq_p)
   );

   // Event pulses: pin change, P match, A match
   assign ev = {pin ^ pin_q, irq_p, irq_a};

   // Sub clock ticks every fourth cycle; watchdog cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      sub_cnt <= sub_cnt + 2'h1;
      pin_q <= pin;
      if (cycles == 60000) begin
         mismatches = mismatches + 1;
         end_sim();
      end
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 check({8'h00, rdata}, {8'h00, exp});
   endtask

   // Spacing in clocks between two consecutive events of one kind
   task automatic gap(input int sel, input logic [15:0] exp);
      int n;
      n = 0;
      while (ev[sel] !== 1'b1 && n < 9000) begin
         @(posedge clk);
         #1 n++;
      end
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (ev[sel] !== 1'b1 && n < 9000);
      check(n[15:0], exp);
   endtask

   // High cycles of the output over 256 clocks
   task automatic high_time(input logic [15:0] exp);
      int n;
      n = 0;
      repeat (256) begin
         @(posedge clk);
         #1 n += (pin === 1'b1) ? 1 : 0;
      end
      check(n[15:0], exp);
   endtask

   task automatic pulses(input int k);
      repeat (k) begin
         repeat (4) @(posedge clk);
         ext_pin <= 1'b1;
         repeat (4) @(posedge clk);
         ext_pin <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic end_sim();
      $display("counts: %0d mismatches, %0d checked", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      reset_n = 1'b0;
      bus = '0;
      ext_pin = 1'b0;
      hi_tick = 1'b1;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      // Reset contents, unmapped place ignores writes
      rd(3'h0, 8'h00);
      rd(3'h1, 8'h00);
      wr(3'h7, 8'hFF);
      rd(3'h7, 8'h00);
      wr(3'h1, 8'hA5);
      rd(3'h1, 8'hA5);
      $display("test reset done");
      // Low write only fills the buffer until the high byte lands
      wr(3'h4, 8'h5A);
      rd(3'h5, 8'h00);
      rd(3'h4, 8'h00);
      // The high read refilled the buffer, so the low byte goes in again first
      wr(3'h4, 8'h5A);
      wr(3'h5, 8'h03);
      rd(3'h5, 8'h03);
      rd(3'h4, 8'h5A);
      $display("test compare bytes done");
      // Every source ratio against P spacing; timer mode keeps the pin low
      wr(3'h1, 8'hC0);
      for (int i = 0; i < 9; i++) begin
         wr(3'h0, {1'b0, cfg[i][5:3], 1'b0, cfg[i][2:0]});
         wr(3'h0, {1'b0, cfg[i][5:3], 1'b1, cfg[i][2:0]});
         gap(1, per[i][15:0]);
         check({15'h0000, pin}, 16'h0000);
      end
      $display("test clock sources done");
      // Clear on A with toggle output; A = 200 clocks
      wr(3'h4, 8'hC8);
      wr(3'h5, 8'h00);
      wr(3'h1, 8'h31);
      wr(3'h0, 8'h10);
      wr(3'h0, 8'h18);
      gap(0, 16'd200);
      gap(2, 16'd200);
      $display("test compare output done");
      // Edge-aligned PWM, period 128 from P, duty 32 from A, then inverted
      wr(3'h4, 8'h20);
      wr(3'h5, 8'h00);
      wr(3'h1, 8'hA8);
      wr(3'h0, 8'h11);
      wr(3'h0, 8'h19);
      repeat (200) @(posedge clk);
      high_time(16'd64);
      wr(3'h0, 8'h11);
      wr(3'h1, 8'hAC);
      wr(3'h0, 8'h19);
      repeat (200) @(posedge clk);
      high_time(16'd192);
      // Swapped roles: period 256 from A, duty 128 from P
      wr(3'h0, 8'h11);
      wr(3'h4, 8'h00);
      wr(3'h5, 8'h01);
      wr(3'h1, 8'hAA);
      wr(3'h0, 8'h19);
      repeat (300) @(posedge clk);
      high_time(16'd128);
      $display("test pwm done");
      // Pin events on rising then falling edge; counter writes are ignored
      wr(3'h1, 8'hC0);
      wr(3'h0, 8'h60);
      wr(3'h0, 8'h68);
      pulses(5);
      // Pause holds the count while edges keep coming
      wr(3'h0, 8'hE8);
      pulses(2);
      wr(3'h0, 8'h60);
      wr(3'h2, 8'hFF);
      wr(3'h3, 8'h03);
      rd(3'h3, 8'h00);
      rd(3'h2, 8'h05);
      wr(3'h0, 8'h70);
      wr(3'h0, 8'h78);
      pulses(3);
      wr(3'h0, 8'h70);
      rd(3'h3, 8'h00);
      rd(3'h2, 8'h03);
      $display("test external clock done");
      end_sim();
   end
endmodule
`default_nettype wire
